// ---- inc/sensor_i2c_pkg.sv ----
// Constants, states and carrier types of the sensor serial register port.
// Assumes one 50 MHz system clock and a bus master clocking at <= 400 kHz.
package sensor_i2c_pkg;

  // Fixed seven-bit slave address and direction bit value
  localparam logic [6:0] SLAVE_ADDR     = 7'h40;
  localparam logic       RW_READ        = 1'b1;

  // Register file shape and reset contents
  localparam int         REG_COUNT      = 256;
  localparam logic [7:0] REG_DEFAULT    = 8'h00;
  localparam logic [7:0] PTR_RESET      = 8'h00;

  // Control register locations and the value that activates them
  localparam logic [7:0] PWRDN_ADDR     = 8'hf0;
  localparam logic [7:0] SRST_ADDR      = 8'hf1;
  localparam logic [7:0] CTL_ACTIVE     = 8'h01;

  // Bit counting within a byte
  localparam logic [3:0] CNT_RESET      = 4'h0;
  localparam logic [3:0] LAST_BIT       = 4'h7;
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  // Bus rate against system clock; sampling margin per SCL period
  localparam int         CLK_KHZ        = 50000;
  localparam int         SCL_MAX_KHZ    = 400;
  localparam int         SCL_MIN_PER_CYC = CLK_KHZ / SCL_MAX_KHZ;

  // Transfer states
  typedef enum logic [3:0]
  {
    ST_IDLE    = 4'b0000,
    ST_ADDR    = 4'b0001,
    ST_ADDR_AK = 4'b0010,
    ST_PTR     = 4'b0011,
    ST_PTR_AK  = 4'b0100,
    ST_WDATA   = 4'b0101,
    ST_WDAT_AK = 4'b0110,
    ST_RDATA   = 4'b0111,
    ST_MACK    = 4'b1000,
    ST_IGNORE  = 4'b1001
  } port_state_t;

  // Sampled pair of bus lines
  typedef struct packed
  {
    logic scl;
    logic sda;
  } line_t;

endpackage

// ---- verilog/sensor_i2c_register_slave.sv ----
// Two-wire slave port with its 256-entry byte register file.
// Assumes SCL and SDA arrive asynchronously; SDA wire level is resolved
// outside from sda_oe (low driven while high).
//
// Overview of operation
// RULE1: Answer only as slave, only to seven-bit address 1000000.
// RULE2: Transfers both ways at SCL up to 400 kHz.
// RULE3: Master alone starts, clocks and stops; the port never does.
// RULE4: SDA falling while SCL high is a start, opening a transfer.
// RULE5: SDA rising while SCL high is a stop, ending the transfer.
// RULE6: The driver keeps SDA stable while SCL high.
// RULE7: Bytes travel most significant bit first, both directions.
// RULE8: First byte LSB one means read, zero means write.
// RULE9: Receiver pulls SDA low on the ninth clock to acknowledge.
// RULE10: In a write, the second byte loads the register pointer.
// RULE11: Following data byte is stored at the pointer.
// RULE12: Master may stop after the last write data acknowledge.
// RULE13: Pointer advances by one after each written data byte.
// RULE14: Every control register can be written by a write cycle.
// RULE15: A read has no pointer byte; it uses the pointer left earlier.
// RULE16: After a read address acknowledge, send the pointed register.
// RULE17: Pointer advances after each sent byte; master ack sends next.
// RULE18: Master leaves SDA high after the last byte it wants.
// RULE19: On no acknowledge, release SDA so the master can stop.
// RULE20: Port keeps working while soft power-down holds 0x01.
// RULE21: Writing 0x01 to soft reset restores all registers to defaults.
// RULE22: Wrong address: stay released, no acknowledge, wait for start.
// RULE23: Start mid-transfer drops the byte and expects an address.
`timescale 1ns/100ps

module sensor_i2c_register_slave
  import sensor_i2c_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      soft_powerdown_ctl
);
  import sensor_i2c_pkg::*;

  line_t       sync1;
  line_t       line;
  line_t       line_q;
  port_state_t state;
  logic [3:0]  cnt;
  logic [7:0]  shift;
  logic [7:0]  tx;
  logic [7:0]  register_pointer_byte;
  logic        master_acknowledge;
  logic [7:0]  regs [REG_COUNT];
  logic        scl_rise;
  logic        scl_fall;
  logic        start_seen;
  logic        stop_seen;
  logic        byte_done;
  logic        addr_match;
  logic        wr_fire;
  logic        soft_register_reset_ctl;

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling

  // Two-stage synchroniser; the first stage feeds nothing else
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1  <= '{scl: 1'b1, sda: 1'b1};
      line   <= '{scl: 1'b1, sda: 1'b1};
      line_q <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      sync1  <= '{scl: scl_in, sda: sda_in};
      line   <= sync1;
      line_q <= line;
    end
  end

  // Edge and framing detection on the synchronised lines
  // 125 clocks per fastest SCL period leave ample margin  [RULE2]
  assign scl_rise   = line.scl & ~line_q.scl;
  assign scl_fall   = ~line.scl & line_q.scl;
  assign start_seen = line.scl & line_q.scl & line_q.sda & ~line.sda; // [RULE4]
  assign stop_seen  = line.scl & line_q.scl & ~line_q.sda & line.sda; // [RULE5]
  assign byte_done  = scl_fall && (cnt == BYTE_BITS);
  assign addr_match = (shift[7:1] == SLAVE_ADDR); // [RULE1]
  assign wr_fire    = (state == ST_WDATA) && byte_done;
  assign soft_register_reset_ctl = wr_fire &&
    (register_pointer_byte == SRST_ADDR) && (shift == CTL_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing
  // The port only follows SCL and framing made by the master  [RULE3]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
    end
    else if (start_seen)
    begin
      state <= ST_ADDR; // Abandon any byte in progress  [RULE23]
    end
    else if (stop_seen)
    begin
      state <= ST_IDLE; // [RULE5]
    end
    else
    begin
      case (state)
        ST_ADDR:
          if (byte_done)
            state <= addr_match ? ST_ADDR_AK : ST_IGNORE; // [RULE22]
        ST_ADDR_AK:
          if (scl_fall)
            state <= (shift[0] == RW_READ) ? ST_RDATA : ST_PTR; // [RULE8]
        ST_PTR:
          if (byte_done)
            state <= ST_PTR_AK; // [RULE10]
        ST_PTR_AK:
          if (scl_fall)
            state <= ST_WDATA;
        ST_WDATA:
          if (byte_done)
            state <= ST_WDAT_AK; // [RULE11]
        ST_WDAT_AK:
          if (scl_fall)
            state <= ST_WDATA; // Further bytes until stop  [RULE12]
        ST_RDATA:
          if (scl_fall && (cnt == LAST_BIT))
            state <= ST_MACK;
        ST_MACK:
          if (scl_fall)
            state <= master_acknowledge ? ST_RDATA : ST_IGNORE; // [RULE18]
        ST_IDLE,
        ST_IGNORE:
          state <= state;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Bit counter: counts rises while receiving, falls while sending
  always_ff @(posedge clk)
  begin
    if (rst || start_seen || stop_seen)
    begin
      cnt <= CNT_RESET;
    end
    else if ((state == ST_ADDR) || (state == ST_PTR) ||
             (state == ST_WDATA))
    begin
      if (byte_done)
        cnt <= CNT_RESET;
      else if (scl_rise)
        cnt <= cnt + 4'h1;
    end
    else if (state == ST_RDATA)
    begin
      if (scl_fall)
        cnt <= (cnt == LAST_BIT) ? CNT_RESET : cnt + 4'h1;
    end
    else
    begin
      cnt <= CNT_RESET;
    end
  end

  // Receive shifter, MSB arrives first  [RULE7]
  // Frozen outside received bytes, so the acknowledge slot cannot
  // shift the direction bit out before it is decoded
  always_ff @(posedge clk)
  begin
    if (rst)
      shift <= 8'h00;
    else if (scl_rise && (cnt != BYTE_BITS) &&
             ((state == ST_ADDR) || (state == ST_PTR) ||
              (state == ST_WDATA)))
      shift <= {shift[6:0], line.sda};
  end

  // Master acknowledge sampled while SCL rises in its slot
  always_ff @(posedge clk)
  begin
    if (rst)
      master_acknowledge <= 1'b0;
    else if ((state == ST_MACK) && scl_rise)
      master_acknowledge <= ~line.sda;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and register file

  // Pointer: loaded by the second write byte, advanced by each data byte written or sent
  always_ff @(posedge clk)
  begin
    if (rst)
      register_pointer_byte <= PTR_RESET;
    else if ((state == ST_PTR) && byte_done)
      register_pointer_byte <= shift; // [RULE10] [RULE15]
    else if (wr_fire)
      register_pointer_byte <= register_pointer_byte + 8'h01; // [RULE13]
    else if ((state == ST_RDATA) && scl_fall && (cnt == LAST_BIT))
      register_pointer_byte <= register_pointer_byte + 8'h01; // [RULE17]
  end

  // Registers; soft reset clears them all but not the port  [RULE21]
  always_ff @(posedge clk)
  begin
    if (rst || soft_register_reset_ctl)
    begin
      for (int i = 0; i < REG_COUNT; i++)
        regs[i] <= REG_DEFAULT;
    end
    else if (wr_fire)
    begin
      regs[register_pointer_byte] <= shift; // [RULE11] [RULE14]
    end
  end

  // Power-down flag for the rest of the chip; never gates this port
  always_ff @(posedge clk)
  begin
    if (rst)
      soft_powerdown_ctl <= 1'b0;
    else
      soft_powerdown_ctl <= (regs[PWRDN_ADDR] == CTL_ACTIVE); // [RULE20]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data line drive; changes only on SCL falls or on release  [RULE6]

  // Transmit byte: loaded when a read byte begins, shifted per fall
  always_ff @(posedge clk)
  begin
    if (rst)
      tx <= 8'h00;
    else if (scl_fall && ((state == ST_ADDR_AK) ||
             ((state == ST_MACK) && master_acknowledge)))
      tx <= regs[register_pointer_byte]; // [RULE16] [RULE17]
    else if ((state == ST_RDATA) && scl_fall)
      tx <= {tx[6:0], 1'b0}; // [RULE7]
  end

  // Open-drain enable; a low is the only level ever driven
  always_ff @(posedge clk)
  begin
    if (rst || start_seen || stop_seen)
      sda_oe <= 1'b0;
    else if (byte_done && ((state != ST_ADDR) || addr_match))
      sda_oe <= 1'b1; // Acknowledge slot  [RULE9] [RULE22]
    else if (scl_fall && (state == ST_ADDR_AK) && (shift[0] == RW_READ))
      sda_oe <= ~regs[register_pointer_byte][7]; // [RULE16]
    else if (scl_fall && (state == ST_MACK) && master_acknowledge)
      sda_oe <= ~regs[register_pointer_byte][7]; // [RULE17]
    else if (scl_fall && (state == ST_RDATA) && (cnt != LAST_BIT))
      sda_oe <= ~tx[6];
    else if (scl_fall)
      sda_oe <= 1'b0; // [RULE19]
  end

  // Data level is a constant low, held in a flop for a clean output
  always_ff @(posedge clk)
  begin
    sda_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_read_last_bit;
    (state == ST_RDATA) && scl_fall && (cnt == LAST_BIT);
  endsequence

  sequence s_master_nack;
    (state == ST_MACK) && scl_fall && !master_acknowledge;
  endsequence

  a_start_rearm: assert property (@(posedge clk) disable iff (rst) // [RULE23]
    start_seen |=> (state == ST_ADDR) && !sda_oe && (cnt == CNT_RESET))
    else $error("start did not rearm address phase");

  a_stop_idle: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    stop_seen |=> (state == ST_IDLE) && !sda_oe)
    else $error("stop did not end transfer");

  a_addr_miss: assert property (@(posedge clk) disable iff (rst) // [RULE22]
    ((state == ST_ADDR) && byte_done && !addr_match && !start_seen &&
     !stop_seen) |=> (state == ST_IGNORE) && !sda_oe)
    else $error("foreign address was acknowledged");

  a_addr_ack: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    ((state == ST_ADDR) && byte_done && addr_match && !start_seen &&
     !stop_seen) |=> (state == ST_ADDR_AK) && sda_oe)
    else $error("own address not acknowledged");

  a_oe_low_scl: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    $rose(sda_oe) |-> !$past(line.scl))
    else $error("data drive began while clock high");

  a_ptr_load: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    ((state == ST_PTR) && byte_done && !start_seen && !stop_seen) |=>
      register_pointer_byte == $past(shift))
    else $error("pointer not loaded from second byte");

  a_wr_incr: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    wr_fire |=> (register_pointer_byte == $past(register_pointer_byte) +
      8'h01) && (regs[$past(register_pointer_byte)] == $past(shift) ||
      $past(soft_register_reset_ctl)))
    else $error("write byte not stored or pointer not advanced");

  a_rd_release: assert property (@(posedge clk) disable iff (rst) // [RULE17]
    (s_read_last_bit and (!start_seen && !stop_seen)) |=>
      (state == ST_MACK) && !sda_oe &&
      (register_pointer_byte == $past(register_pointer_byte) + 8'h01))
    else $error("read byte end mishandled");

  a_nack_free: assert property (@(posedge clk) disable iff (rst) // [RULE19]
    (s_master_nack and (!start_seen && !stop_seen)) |=>
      ((state == ST_IGNORE) && !sda_oe)[*2])
    else $error("line not released after no acknowledge");

  a_soft_reset: assert property (@(posedge clk) disable iff (rst) // [RULE21]
    soft_register_reset_ctl |=> (regs[PWRDN_ADDR] == REG_DEFAULT)
      ##1 !soft_powerdown_ctl)
    else $error("soft reset left registers set");

endmodule

// ---- bench/i2c_master_model.sv ----
// Behavioural two-wire bus master that drives the serial port under test.
// Assumes the bench resolves SDA from sda_low, the port's enable and a
// pull-up, and feeds that level back on sda_wire.
`timescale 1ns/100ps

module i2c_master_model (
  input  wire logic clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_low
);
  // 160 ns SCL period; the port answers within three clocks of a fall,
  // so four low clocks are the least that still leaves setup margin
  localparam int LOW_CYC  = 4;
  localparam int HIGH_CYC = 4;

  // Clock idles high and stands still between frames
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One clock pulse; data moves only while the clock is low
  task automatic clk_bit(input logic b, output logic s);
    repeat (2) @(negedge clk);
    sda_low = ~b;
    repeat (LOW_CYC - 2) @(negedge clk);
    scl = 1'b1;
    repeat (HIGH_CYC) @(negedge clk);
    s   = sda_wire;
    scl = 1'b0;
  endtask

  // Data falls while the clock is high; works as a repeated start too
  task automatic start_cond();
    repeat (2) @(negedge clk);
    sda_low = 1'b0;
    repeat (LOW_CYC) @(negedge clk);
    scl = 1'b1;
    repeat (HIGH_CYC) @(negedge clk);
    sda_low = 1'b1;
    repeat (HIGH_CYC) @(negedge clk);
    scl = 1'b0;
  endtask

  // Data rises while the clock is high, then the bus is left idle
  task automatic stop_cond();
    repeat (2) @(negedge clk);
    sda_low = 1'b1;
    repeat (LOW_CYC) @(negedge clk);
    scl = 1'b1;
    repeat (HIGH_CYC) @(negedge clk);
    sda_low = 1'b0;
    repeat (HIGH_CYC) @(negedge clk);
  endtask

  // Eight bits then the acknowledge slot; tx of all ones reads
  task automatic xfer_byte(input  logic [7:0] tx,
                           input  logic       ack_in,
                           output logic [7:0] rx,
                           output logic       ack_seen);
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(ack_in, ack_seen);
  endtask
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the serial register port.
// Assumes the master model above and a pulled-up SDA wire.
`timescale 1ns/100ps

module tb;
  import sensor_i2c_pkg::*;

  logic clk;
  logic rst;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic soft_powerdown_ctl;
  logic sda_wire;
  int   fails       = 0;
  int   checks_done = 0;
  int   cycles      = 0;

  // Wire level from both parties' pull-downs and the pull-up
  assign sda_wire = ~sda_low & ~(sda_oe & ~sda_out);

  sensor_i2c_register_slave u_dut (
    .clk                (clk),
    .rst                (rst),
    .scl_in             (scl),
    .sda_in             (sda_wire),
    .sda_out            (sda_out),
    .sda_oe             (sda_oe),
    .soft_powerdown_ctl (soft_powerdown_ctl)
  );

  i2c_master_model u_master (
    .clk      (clk),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda_low  (sda_low)
  );

  // System clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Write cycle: pointer byte then n data bytes, each acknowledged
  task automatic wr_regs(input logic [7:0] ptr, input logic [15:0] d,
                         input int n);
    logic [7:0] rx;
    logic       ak;
    u_master.start_cond();
    u_master.xfer_byte(8'h80, 1'b1, rx, ak);
    check({7'h00, ak}, 8'h00);
    u_master.xfer_byte(ptr, 1'b1, rx, ak);
    check({7'h00, ak}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      u_master.xfer_byte(d[15 - 8 * i -: 8], 1'b1, rx, ak);
      check({7'h00, ak}, 8'h00);
    end
    u_master.stop_cond();
  endtask

  // Read cycle: n bytes, the last one left unacknowledged
  task automatic rd_regs(input int n, input logic [15:0] e);
    logic [7:0] rx;
    logic       ak;
    u_master.start_cond();
    u_master.xfer_byte(8'h81, 1'b1, rx, ak);
    check({7'h00, ak}, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      u_master.xfer_byte(8'hff, (i == n - 1), rx, ak);
      check(rx, e[15 - 8 * i -: 8]);
    end
    check({7'h00, ak}, 8'h01);
    u_master.stop_cond();
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    check({5'h00, sda_out, sda_oe, soft_powerdown_ctl}, 8'h00);
    rd_regs(2, 16'h0000);
    $display("t_defaults done");
  endtask

  task automatic t_write_read();
    wr_regs(8'h10, 16'ha53c, 2);
    wr_regs(8'h10, 16'h0000, 0);
    rd_regs(2, 16'ha53c);
    $display("t_write_read done");
  endtask

  // Foreign addresses get no answer and cannot move the pointer
  task automatic t_bad_addr();
    logic [7:0] rx;
    logic       ak;
    logic [7:0] bad [4] = '{8'h82, 8'h00, 8'hc1, 8'h7e};
    wr_regs(8'h11, 16'h0000, 0);
    foreach (bad[i])
    begin
      u_master.start_cond();
      u_master.xfer_byte(bad[i], 1'b1, rx, ak);
      check({7'h00, ak}, 8'h01);
      u_master.xfer_byte(8'h10, 1'b1, rx, ak);
      check({7'h00, ak}, 8'h01);
      u_master.stop_cond();
    end
    rd_regs(1, 16'h3c00);
    $display("t_bad_addr done");
  endtask

  // Start in the middle of an address byte
  task automatic t_restart();
    logic ak;
    u_master.start_cond();
    u_master.clk_bit(1'b1, ak);
    u_master.clk_bit(1'b0, ak);
    u_master.clk_bit(1'b0, ak);
    wr_regs(8'h20, 16'h5a00, 1);
    wr_regs(8'h20, 16'h0000, 0);
    rd_regs(1, 16'h5a00);
    $display("t_restart done");
  endtask

  task automatic t_ctl();
    wr_regs(PWRDN_ADDR, {CTL_ACTIVE, 8'h00}, 1);
    check({7'h00, soft_powerdown_ctl}, 8'h01);
    wr_regs(PWRDN_ADDR, 16'h0000, 0);
    rd_regs(1, {CTL_ACTIVE, 8'h00});
    wr_regs(SRST_ADDR, {CTL_ACTIVE, 8'h00}, 1);
    check({7'h00, soft_powerdown_ctl}, 8'h00);
    wr_regs(8'h10, 16'h0000, 0);
    rd_regs(2, 16'h0000);
    $display("t_ctl done");
  endtask

  // Hang guard: about twice the expected run length
  initial
  begin
    forever
    begin
      @(posedge clk);
      cycles++;
      if (cycles == 8000)
      begin
        fails++;
        wrap_up();
      end
    end
  end

  // Reset for 16 cycles, then the scenarios
  initial
  begin
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_defaults();
    t_write_read();
    t_bad_addr();
    t_restart();
    t_ctl();
    wrap_up();
  end
endmodule
